// ==== rtl/ccs_top.sv ====
// What this block does
// - Hold six-bit offset code, reset 100000b
// - One offset setting drives both inputs
// - Two-bit range code selects range capacitor
// - One range setting drives both inputs
// - Input A: seventeen switch bits, reset zero
// - Input B: seventeen switch bits, reset zero
// - Overlapping selections flag error, block conversions
// - Result below low threshold flags event
// - Result above high threshold flags event
// - Three enable bits, reset zero
// - Raw status read-only, ignores enables
// - Bit 0 set on each conversion taken while selections do not overlap
// - Bit 1 set when result below low
// - Bit 2 set when result above high
// - Status bit 7 shows switch overlap
// - Reading result clears pending conditions
// - Masked status is raw AND enable
// - Writing ones to clear register clears flags
`timescale 1ns/1ps
module ccs_top
  import ccs_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic [ccs_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ccs_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [ccs_pkg::STRB_W-1:0]    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ccs_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [ccs_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          conv_done,
  input  wire logic [ccs_pkg::RESULT_W-1:0]  conv_result,
  output logic [ccs_pkg::OFFSET_CAP_W-1:0]   offset_cap_code,
  output logic [ccs_pkg::RANGE_CAP_W-1:0]    range_cap_sel,
  output logic [ccs_pkg::SWITCH_W-1:0]       input_a_switch_select,
  output logic [ccs_pkg::SWITCH_W-1:0]       input_b_switch_select,
  output logic                               switch_overlap_error,
  output logic                               conv_permit,
  output logic                               irq_request
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic                wr_fire;
  logic [ADDR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic [STRB_W-1:0]   wr_strb;
  logic                rd_fire;
  logic [ADDR_W-1:0]   rd_addr;
  logic [DATA_W-1:0]   rd_word;
  logic [DATA_W-1:0]   wr_merged;
  logic [THR_W-1:0]    low_threshold;
  logic [THR_W-1:0]    high_threshold;
  logic [EVT_W-1:0]    irq_enable;
  logic [EVT_W-1:0]    raw_flags;
  logic [EVT_W-1:0]    set_evt;
  logic [EVT_W-1:0]    clr_evt;
  logic [RESULT_W-1:0] result_q;
  logic                overlap_now;
  logic                conv_taken;

  ccs_axil_slave ccs_axil_slave_inst (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .ce         (ce),
    .awaddr     (s_axi_awaddr),
    .awvalid    (s_axi_awvalid),
    .awready    (s_axi_awready),
    .wdata      (s_axi_wdata),
    .wstrb      (s_axi_wstrb),
    .wvalid     (s_axi_wvalid),
    .wready     (s_axi_wready),
    .bresp      (s_axi_bresp),
    .bvalid     (s_axi_bvalid),
    .bready     (s_axi_bready),
    .araddr     (s_axi_araddr),
    .arvalid    (s_axi_arvalid),
    .arready    (s_axi_arready),
    .rdata      (s_axi_rdata),
    .rresp      (s_axi_rresp),
    .rvalid     (s_axi_rvalid),
    .rready     (s_axi_rready),
    .wr_fire    (wr_fire),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .wr_strb    (wr_strb),
    .rd_fire    (rd_fire),
    .rd_addr    (rd_addr),
    .rd_word    (rd_word)
  );

  // Current contents of a register word, reserved bits as zero
  function automatic logic [DATA_W-1:0] reg_word(input logic [ADDR_W-1:0] addr);
    logic [DATA_W-1:0] word;
    word = '0;
    unique case (addr)
      ADDR_RESULT:     word[RESULT_W-1:0]     = result_q;
      ADDR_STATUS:     word[STATUS_OVERLAP_BIT] = overlap_now;
      ADDR_OFFSET_CAP: word[OFFSET_CAP_W-1:0] = offset_cap_code;
      ADDR_RANGE_CAP:  word[RANGE_CAP_W-1:0]  = range_cap_sel;
      ADDR_IN_A:       word[SWITCH_W-1:0]     = input_a_switch_select;
      ADDR_IN_B:       word[SWITCH_W-1:0]     = input_b_switch_select;
      ADDR_LOW_THR:    word[THR_W-1:0]        = low_threshold;
      ADDR_HIGH_THR:   word[THR_W-1:0]        = high_threshold;
      ADDR_IRQ_EN:     word[EVT_W-1:0]        = irq_enable;
      ADDR_IRQ_RAW:    word[EVT_W-1:0]        = raw_flags;
      ADDR_IRQ_MASKED: word[EVT_W-1:0]        = raw_flags & irq_enable;
      default:         word                   = '0;
    endcase
    return word;
  endfunction : reg_word

  // A process, so that a register change re-runs the lookup as well
  always_comb begin
    rd_word   = reg_word(rd_addr);
    wr_merged = ccs_apply_strb(reg_word(wr_addr), wr_data, wr_strb);
  end

  // ----------------------------------------------------------------
  // Capacitor settings, shared by both converter inputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      offset_cap_code <= OFFSET_CAP_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_OFFSET_CAP) begin
      offset_cap_code <= wr_merged[OFFSET_CAP_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      range_cap_sel <= RANGE_CAP_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_RANGE_CAP) begin
      range_cap_sel <= wr_merged[RANGE_CAP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Switch matrix selections, a one connects the input
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_a_switch_select <= SWITCH_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_IN_A) begin
      input_a_switch_select <= wr_merged[SWITCH_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_b_switch_select <= SWITCH_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_IN_B) begin
      input_b_switch_select <= wr_merged[SWITCH_W-1:0];
    end
  end

  assign overlap_now = |(input_a_switch_select & input_b_switch_select);
  assign conv_permit = ~overlap_now;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      switch_overlap_error <= 1'b0;
    end else if (ce) begin
      switch_overlap_error <= overlap_now;
    end
  end

  // ----------------------------------------------------------------
  // Thresholds and enables
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_threshold <= THR_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_LOW_THR) begin
      low_threshold <= wr_merged[THR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      high_threshold <= THR_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_HIGH_THR) begin
      high_threshold <= wr_merged[THR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= IRQ_EN_RST;
    end else if (ce && wr_fire && wr_addr == ADDR_IRQ_EN) begin
      irq_enable <= wr_merged[EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Finished conversions and event flags
  // ----------------------------------------------------------------
  assign conv_taken = ce & conv_done & ~overlap_now;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result_q <= '0;
    end else if (conv_taken) begin
      result_q <= conv_result;
    end
  end

  always_comb begin
    set_evt            = '0;
    set_evt[EVT_READY] = conv_taken;
    set_evt[EVT_BELOW] = conv_taken && (conv_result < low_threshold);
    set_evt[EVT_ABOVE] = conv_taken && (conv_result > high_threshold);
  end

  always_comb begin
    clr_evt = '0;
    if (rd_fire && rd_addr == ADDR_RESULT) begin
      clr_evt = '1;
    end
    if (wr_fire && wr_addr == ADDR_IRQ_CLEAR && wr_strb[0]) begin
      clr_evt = clr_evt | wr_data[EVT_W-1:0];
    end
  end

  ccs_event_flags ccs_event_flags_inst (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .ce         (ce),
    .set_evt    (set_evt),
    .clr_evt    (clr_evt),
    .flags      (raw_flags)
  );

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_request <= 1'b0;
    end else if (ce) begin
      irq_request <= |(raw_flags & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence seq_write_to(logic [ADDR_W-1:0] a);
    ce && wr_fire && wr_addr == a && wr_strb == 4'hF;
  endsequence

  sequence seq_result_read;
    rd_fire && rd_addr == ADDR_RESULT && !conv_taken;
  endsequence

  a_offset_write: assert property (seq_write_to(ADDR_OFFSET_CAP) |=>
      offset_cap_code == $past(wr_data[OFFSET_CAP_W-1:0]) && s_axi_bvalid)
    else $error("offset code not taken from write");

  a_range_write: assert property (seq_write_to(ADDR_RANGE_CAP) |=>
      range_cap_sel == $past(wr_data[RANGE_CAP_W-1:0]))
    else $error("range code not taken from write");

  a_sel_a_write: assert property (seq_write_to(ADDR_IN_A) |=>
      input_a_switch_select == $past(wr_data[SWITCH_W-1:0]))
    else $error("input A selection not taken from write");

  a_sel_b_write: assert property (seq_write_to(ADDR_IN_B) |=>
      input_b_switch_select == $past(wr_data[SWITCH_W-1:0]))
    else $error("input B selection not taken from write");

  a_low_write: assert property (seq_write_to(ADDR_LOW_THR) |=>
      low_threshold == $past(wr_data[THR_W-1:0]))
    else $error("low threshold not taken from write");

  a_high_write: assert property (seq_write_to(ADDR_HIGH_THR) |=>
      high_threshold == $past(wr_data[THR_W-1:0]))
    else $error("high threshold not taken from write");

  a_enable_write: assert property (seq_write_to(ADDR_IRQ_EN) |=>
      irq_enable == $past(wr_data[EVT_W-1:0]))
    else $error("enable bits not taken from write");

  a_overlap_flag: assert property (ce |=>
      switch_overlap_error == $past(overlap_now))
    else $error("overlap error does not follow switch selections");

  a_refuse_conv: assert property (ce && conv_done && overlap_now |=>
      $stable(result_q) && !$rose(raw_flags[EVT_READY]))
    else $error("conversion accepted despite overlap");

  a_ready_set: assert property (conv_taken |=> raw_flags[EVT_READY]
      && result_q == $past(conv_result))
    else $error("ready flag or result not latched");

  a_below_set: assert property (conv_taken && conv_result < low_threshold
      |=> raw_flags[EVT_BELOW])
    else $error("below flag not set");

  a_above_set: assert property (conv_taken && conv_result > high_threshold
      |=> raw_flags[EVT_ABOVE])
    else $error("above flag not set");

  a_masked_irq: assert property (ce |=> irq_request == |$past(raw_flags & irq_enable))
    else $error("interrupt request does not follow masked status");

  a_result_clear: assert property (seq_result_read |=> raw_flags == '0)
    else $error("result read did not clear flags");

  a_clear_write: assert property (ce && wr_fire && wr_addr == ADDR_IRQ_CLEAR
      && wr_strb[0] && !conv_taken |=> (raw_flags & $past(wr_data[EVT_W-1:0])) == '0)
    else $error("clear register write did not clear flags");

endmodule : ccs_top

// ==== rtl/ccs_pkg.sv ====
package ccs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 32;
  localparam int STRB_W        = 4;
  localparam int OFFSET_CAP_W  = 6;
  localparam int RANGE_CAP_W   = 2;
  localparam int SWITCH_W      = 17;
  localparam int THR_W         = 16;
  localparam int RESULT_W      = 16;
  localparam int EVT_W         = 3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RESULT     = 32'h4006_4004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 32'h4006_4008;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_CAP = 32'h4006_4010;
  localparam logic [ADDR_W-1:0] ADDR_RANGE_CAP  = 32'h4006_4014;
  localparam logic [ADDR_W-1:0] ADDR_IN_A       = 32'h4006_4018;
  localparam logic [ADDR_W-1:0] ADDR_IN_B       = 32'h4006_401C;
  localparam logic [ADDR_W-1:0] ADDR_LOW_THR    = 32'h4006_4020;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_THR   = 32'h4006_4024;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN     = 32'h4006_4028;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_RAW    = 32'h4006_402C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASKED = 32'h4006_4030;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 32'h4006_4034;

  // ----------------------------------------------------------------
  // Reset values, field positions, codes
  // ----------------------------------------------------------------
  localparam logic [OFFSET_CAP_W-1:0] OFFSET_CAP_RST = 6'h20;
  localparam logic [RANGE_CAP_W-1:0]  RANGE_CAP_RST  = 2'h0;
  localparam logic [SWITCH_W-1:0]     SWITCH_RST     = 17'h0_0000;
  localparam logic [THR_W-1:0]        THR_RST        = 16'h0000;
  localparam logic [EVT_W-1:0]        IRQ_EN_RST     = 3'h0;
  localparam int OFFSET_CAP_STEP_FF  = 100;
  localparam int EVT_READY           = 0;
  localparam int EVT_BELOW           = 1;
  localparam int EVT_ABOVE           = 2;
  localparam int STATUS_OVERLAP_BIT  = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [RANGE_CAP_W-1:0] {
    CCS_RANGE_400F = 2'b00,
    CCS_RANGE_800F = 2'b01,
    CCS_RANGE_1PF  = 2'b10,
    CCS_RANGE_RSVD = 2'b11
  } ccs_range_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] ccs_apply_strb(input logic [DATA_W-1:0] old_word,
                                                       input logic [DATA_W-1:0] new_word,
                                                       input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] merged;
    merged = old_word;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        merged[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return merged;
  endfunction : ccs_apply_strb

  function automatic logic ccs_is_writable(input logic [ADDR_W-1:0] addr);
    return addr inside {ADDR_OFFSET_CAP, ADDR_RANGE_CAP, ADDR_IN_A, ADDR_IN_B,
                        ADDR_LOW_THR, ADDR_HIGH_THR, ADDR_IRQ_EN, ADDR_IRQ_CLEAR};
  endfunction : ccs_is_writable

  function automatic logic ccs_is_readable(input logic [ADDR_W-1:0] addr);
    return (addr != ADDR_IRQ_CLEAR) && (ccs_is_writable(addr) ||
           (addr inside {ADDR_RESULT, ADDR_STATUS, ADDR_IRQ_RAW, ADDR_IRQ_MASKED}));
  endfunction : ccs_is_readable

endpackage : ccs_pkg

// ==== rtl/ccs_event_flags.sv ====
`timescale 1ns/1ps
module ccs_event_flags
  import ccs_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_sync_n,
  input  wire logic                     ce,
  input  wire logic [ccs_pkg::EVT_W-1:0] set_evt,
  input  wire logic [ccs_pkg::EVT_W-1:0] clr_evt,
  output logic      [ccs_pkg::EVT_W-1:0] flags
);

  // ----------------------------------------------------------------
  // Sticky flags, a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags <= '0;
    end else if (ce) begin
      flags <= (flags & ~clr_evt) | set_evt;
    end
  end

endmodule : ccs_event_flags

// ==== rtl/ccs_axil_slave.sv ====
`timescale 1ns/1ps
module ccs_axil_slave
  import ccs_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst_sync_n,
  input  wire logic                       ce,
  input  wire logic [ccs_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [ccs_pkg::DATA_W-1:0] wdata,
  input  wire logic [ccs_pkg::STRB_W-1:0] wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [ccs_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [ccs_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic                            wr_fire,
  output logic [ccs_pkg::ADDR_W-1:0]      wr_addr,
  output logic [ccs_pkg::DATA_W-1:0]      wr_data,
  output logic [ccs_pkg::STRB_W-1:0]      wr_strb,
  output logic                            rd_fire,
  output logic [ccs_pkg::ADDR_W-1:0]      rd_addr,
  input  wire logic [ccs_pkg::DATA_W-1:0] rd_word
);

  logic aw_held;
  logic w_held;

  assign awready = ce & ~aw_held & ~bvalid;
  assign wready  = ce & ~w_held & ~bvalid;
  assign wr_fire = ce & aw_held & w_held & ~bvalid;
  assign arready = ce & ~rvalid;
  assign rd_fire = arvalid & arready;
  assign rd_addr = araddr;

  // ----------------------------------------------------------------
  // Write address and data, taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      w_held  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= ccs_is_writable(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (ce && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel, data registered at the address handshake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= ccs_is_readable(araddr) ? rd_word : '0;
      rresp  <= ccs_is_readable(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (ce && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : ccs_axil_slave

// ==== test/cap_converter_setup_and_irq_tb.sv ====
`timescale 1ns/1ps
module cap_converter_setup_and_irq_tb;
  import ccs_pkg::*;
  // --------------------------------
  // Stimulus and design
  // --------------------------------
  logic mclk = 1'h0, rst_n = 1'h0, ce = 1'h1, conv_done = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [15:0] conv_result = 16'h0000;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rd;
  logic [1:0] wrs, rds;
  int err_count = 0, n_checks = 0;
  logic [31:0] ad [8] = '{ADDR_OFFSET_CAP, ADDR_RANGE_CAP, ADDR_IN_A, ADDR_IN_B, ADDR_LOW_THR, ADDR_HIGH_THR,
                          ADDR_IRQ_EN, ADDR_IRQ_RAW};
  logic [31:0] mk [8] = '{32'h3F, 32'h3, 32'h1FFFF, 32'h1FFFF, 32'hFFFF, 32'hFFFF, 32'h7, 32'h0};
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, switch_overlap_error;
  wire conv_permit, irq_request;
  wire [1:0] s_axi_bresp, s_axi_rresp, range_cap_sel;
  wire [31:0] s_axi_rdata;
  wire [5:0] offset_cap_code;
  wire [16:0] input_a_switch_select, input_b_switch_select;
  ccs_top ccs_top_inst (.mclk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conv_done, .conv_result, .offset_cap_code, .range_cap_sel, .input_a_switch_select,
    .input_b_switch_select, .switch_overlap_error, .conv_permit, .irq_request);
  always #50 mclk = ~mclk;
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    wrs = s_axi_bresp;
    if (n == 50) begin
      err_count++;
      close_out();
    end
  endtask : axw
  task automatic axr(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    rd = s_axi_rdata;
    rds = s_axi_rresp;
    if (n == 50) begin
      err_count++;
      close_out();
    end
  endtask : axr
  task automatic conv(input logic [15:0] r);
    conv_done <= 1'h1;
    conv_result <= r;
    @(posedge mclk);
    conv_done <= 1'h0;
    @(posedge mclk);
  endtask : conv
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      axr(ad[i]);
      chk("reset", rd, (i == 0) ? 32'h20 : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      axw(ad[i], 32'hFFFF_FFFF);
      chk("wresp", wrs, (i == 7) ? RESP_SLVERR : RESP_OKAY);
      axr(ad[i]);
      chk("rdback", rd, mk[i]);
    end
    chk("offset", offset_cap_code, 32'h3F);
    chk("range", range_cap_sel, 32'h3);
    chk("sel_a", input_a_switch_select, 32'h1FFFF);
    chk("sel_b", input_b_switch_select, 32'h1FFFF);
    chk("overlap", switch_overlap_error, 32'h1);
    chk("permit", conv_permit, 32'h0);
    axr(ADDR_STATUS);
    chk("status", rd, 32'h80);
    conv(16'h0005);
    axr(ADDR_IRQ_RAW);
    chk("blocked", rd, 32'h0);
  endtask : t_regs
  task automatic t_conv;
    axw(ADDR_IN_A, 32'h1);
    axw(ADDR_IN_B, 32'h2);
    axw(ADDR_LOW_THR, 32'hA);
    axw(ADDR_HIGH_THR, 32'h14);
    axw(ADDR_IRQ_EN, 32'h2);
    axr(ADDR_STATUS);
    chk("status", rd, 32'h0);
    chk("permit", conv_permit, 32'h1);
    conv(16'h000A);
    axr(ADDR_IRQ_RAW);
    chk("raw_eq", rd, 32'h1);
    axr(ADDR_RESULT);
    chk("result", rd, 32'hA);
    axr(ADDR_IRQ_RAW);
    chk("raw_rd", rd, 32'h0);
    conv(16'h0005);
    axr(ADDR_IRQ_MASKED);
    chk("masked", rd, 32'h2);
    axr(ADDR_IRQ_RAW);
    chk("raw_lo", rd, 32'h3);
    chk("irq", irq_request, 32'h1);
    axw(ADDR_IRQ_CLEAR, 32'h3);
    axr(ADDR_IRQ_RAW);
    chk("raw_clr", rd, 32'h0);
    chk("irq_off", irq_request, 32'h0);
    conv(16'h0015);
    axr(ADDR_IRQ_RAW);
    chk("raw_hi", rd, 32'h5);
    axw(ADDR_IRQ_CLEAR, 32'h4);
    axr(ADDR_IRQ_RAW);
    chk("raw_clr4", rd, 32'h1);
    axr(32'h4006_4038);
    chk("unmapped", {rd[29:0], rds}, {30'h0, RESP_SLVERR});
    ce <= 1'h0;
    conv(16'h0005);
    ce <= 1'h1;
    axr(ADDR_IRQ_RAW);
    chk("ce_low", rd, 32'h1);
  endtask : t_conv
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_conv();
    close_out();
  end
endmodule : cap_converter_setup_and_irq_tb
